// File: hdl/tbt_consts.svh
`ifndef TBT_CONSTS_SVH
`define TBT_CONSTS_SVH
`define OFF_PAGE_SELECT     8'hCC
`define OFF_PMD_CONTROL     8'hE4
`define OFF_TBT_CONTROL     8'hE8
`define OFF_DSP_CONFIG      8'hF4
`define OFF_SIG_DETECT      8'hF8
`define OFF_TEST_DATA       8'hFC
`define TBT_RESET           16'h0004
`define TBT_WR_MASK         16'h01EF
`define TBT_RSVD_ONE        16'h0004
`define BIT_LOOP            8
`define BIT_LP_SUPPRESS     7
`define BIT_FORCE_LINK      6
`define BIT_POL_OVERRIDE    5
`define BIT_POL_STATUS      4
`define BIT_AUTOPOL_OFF     3
`define BIT_SQE_OFF         1
`define BIT_GUARD_OFF       0
`define REG_RESET_ZERO      16'h0000
`endif

// File: hdl/tbt_pkg.sv
package tbt_pkg;
    typedef logic [7:0]  reg_addr_t;
    typedef logic [15:0] reg_word_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } acc_state_e;
endpackage

// File: hdl/pol_latch_if.sv
`timescale 1ns/100ps
interface pol_latch_if;
    logic detect;
    logic clear;
    logic latched;
    modport owner (input detect, input clear, output latched);
    modport user  (output detect, output clear, input latched);
endinterface

// File: hdl/pol_latch.sv
`timescale 1ns/100ps
module pol_latch (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // flag
    pol_latch_if.owner pl
);
    logic latched_r;
    logic latched_nxt;
    // set wins over a read-clear in the same cycle
    always_comb begin
        latched_nxt = latched_r;
        if (pl.clear) begin
            latched_nxt = 1'b0;
        end
        if (pl.detect) begin
            latched_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            latched_r <= 1'b0;
        end else begin
            latched_r <= latched_nxt;
        end
    end
    assign pl.latched = latched_r;
endmodule // pol_latch

// File: hdl/tenbase_t_phy_control.sv
// How it works
// - loopback is register bit or control loopback
// - link pulse suppress ORed with mac override
// - good link forced by bit or mac
// - bit five forces inverted receive polarity
// - latched polarity status, cleared by either read
// - bit three turns off auto polarity
// - sqe test only in half duplex ten
// - bit zero turns off jabber guard
`timescale 1ns/100ps
`include "tbt_consts.svh"
module tenbase_t_phy_control (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // register port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire tbt_pkg::reg_addr_t reg_addr,
    input  wire tbt_pkg::reg_word_t reg_wdata,
    output logic                    reg_ack,
    output tbt_pkg::reg_word_t      reg_rdata,
    // phy side inputs
    input  wire logic               ctrl_loopback,
    input  wire logic               mac_slow_link_override,
    input  wire logic               link_detected,
    input  wire logic               polarity_inverted_seen,
    input  wire logic               phy_status_word_read,
    input  wire logic               speed_fast,
    input  wire logic               full_duplex,
    // phy side controls
    output logic                    slow_loopback_en,
    output logic                    normal_link_pulse_en,
    output logic                    slow_link_good,
    output logic                    inverted_polarity_override,
    output logic                    auto_polarity_en,
    output logic                    sqe_test_en,
    output logic                    long_tx_guard_en,
    output logic                    phy_status_pol_bit,
    // tuning registers
    output tbt_pkg::reg_word_t      page_select,
    output tbt_pkg::reg_word_t      pmd_control_status,
    output tbt_pkg::reg_word_t      dsp_configuration,
    output tbt_pkg::reg_word_t      signal_detect_configuration,
    output tbt_pkg::reg_word_t      test_data_port
);
    import tbt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register state
    reg_word_t  ctl_r,  ctl_nxt;
    reg_word_t  pg_r,   pg_nxt;
    reg_word_t  pmd_r,  pmd_nxt;
    reg_word_t  dsp_r,  dsp_nxt;
    reg_word_t  sd_r,   sd_nxt;
    reg_word_t  tst_r,  tst_nxt;
    reg_word_t  rdata_r, rdata_nxt;
    logic       ack_r,  ack_nxt;
    acc_state_e st_r,   st_nxt;
    logic       pol_seen_s1_r, pol_seen_s2_r;
    logic       pol_clear;
    reg_word_t  ctl_view;

    pol_latch_if pl_bus ();
    pol_latch u_pol (
        .clk  (clk),
        .rstn (rstn),
        .pl   (pl_bus.owner)
    );

    // polarity detect comes from analog side timing, so resync it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pol_seen_s1_r <= 1'b0;
            pol_seen_s2_r <= 1'b0;
        end else begin
            pol_seen_s1_r <= polarity_inverted_seen;
            pol_seen_s2_r <= pol_seen_s1_r;
        end
    end

    // a read of either copy clears both copies
    // a write wins over a read in one cycle, so only a taken read clears
    assign pol_clear = (reg_rd && !reg_wr && (reg_addr == `OFF_TBT_CONTROL)) ||
                       phy_status_word_read;
    assign pl_bus.detect = pol_seen_s2_r;
    assign pl_bus.clear  = pol_clear;

    // upper bits are never stored, so they read zero
    always_comb begin
        ctl_view = ctl_r & `TBT_WR_MASK;
        ctl_view[`BIT_POL_STATUS] = pl_bus.latched;
    end

    ////////////////////////////////////////////////////////////////////////////
    // access handling
    always_comb begin
        ctl_nxt   = ctl_r;
        pg_nxt    = pg_r;
        pmd_nxt   = pmd_r;
        dsp_nxt   = dsp_r;
        sd_nxt    = sd_r;
        tst_nxt   = tst_r;
        rdata_nxt = rdata_r;
        ack_nxt   = 1'b0;
        st_nxt    = ST_IDLE;
        case (st_r)
            ST_IDLE, ST_WRITE, ST_READ: begin
                if (reg_wr) begin
                    st_nxt  = ST_WRITE;
                    ack_nxt = 1'b1;
                    case (reg_addr)
                        `OFF_PAGE_SELECT: pg_nxt  = reg_wdata;
                        `OFF_PMD_CONTROL: pmd_nxt = reg_wdata;
                        `OFF_DSP_CONFIG:  dsp_nxt = reg_wdata;
                        `OFF_SIG_DETECT:  sd_nxt  = reg_wdata;
                        `OFF_TEST_DATA:   tst_nxt = reg_wdata;
                        // bit two is kept at one whatever software writes
                        `OFF_TBT_CONTROL: ctl_nxt = (reg_wdata & `TBT_WR_MASK &
                                                     ~`TBT_RSVD_ONE) |
                                                    `TBT_RSVD_ONE;
                        default: begin
                        end
                    endcase
                end else if (reg_rd) begin
                    st_nxt  = ST_READ;
                    ack_nxt = 1'b1;
                    case (reg_addr)
                        `OFF_PAGE_SELECT: rdata_nxt = pg_r;
                        `OFF_PMD_CONTROL: rdata_nxt = pmd_r;
                        `OFF_DSP_CONFIG:  rdata_nxt = dsp_r;
                        `OFF_SIG_DETECT:  rdata_nxt = sd_r;
                        `OFF_TEST_DATA:   rdata_nxt = tst_r;
                        `OFF_TBT_CONTROL: rdata_nxt = ctl_view;
                        default:          rdata_nxt = `REG_RESET_ZERO;
                    endcase
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_r   <= `TBT_RESET;
            pg_r    <= `REG_RESET_ZERO;
            pmd_r   <= `REG_RESET_ZERO;
            dsp_r   <= `REG_RESET_ZERO;
            sd_r    <= `REG_RESET_ZERO;
            tst_r   <= `REG_RESET_ZERO;
            rdata_r <= `REG_RESET_ZERO;
            ack_r   <= 1'b0;
            st_r    <= ST_IDLE;
        end else begin
            ctl_r   <= ctl_nxt;
            pg_r    <= pg_nxt;
            pmd_r   <= pmd_nxt;
            dsp_r   <= dsp_nxt;
            sd_r    <= sd_nxt;
            tst_r   <= tst_nxt;
            rdata_r <= rdata_nxt;
            ack_r   <= ack_nxt;
            st_r    <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // phy controls, registered so every output is a flop
    logic [7:0] ctrl_nxt, ctrl_r;
    logic       half_ten;
    assign half_ten = !speed_fast && !full_duplex;
    always_comb begin
        ctrl_nxt[0] = ctl_r[`BIT_LOOP] | ctrl_loopback;
        ctrl_nxt[1] = !(ctl_r[`BIT_LP_SUPPRESS] | mac_slow_link_override);
        ctrl_nxt[2] = ctl_r[`BIT_FORCE_LINK] | mac_slow_link_override |
                      link_detected;
        ctrl_nxt[3] = ctl_r[`BIT_POL_OVERRIDE];
        ctrl_nxt[4] = !ctl_r[`BIT_AUTOPOL_OFF];
        // outside half duplex ten the sqe test is always off
        ctrl_nxt[5] = half_ten && !ctl_r[`BIT_SQE_OFF];
        ctrl_nxt[6] = !ctl_r[`BIT_GUARD_OFF];
        ctrl_nxt[7] = pl_bus.latched;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign slow_loopback_en            = ctrl_r[0];
    assign normal_link_pulse_en        = ctrl_r[1];
    assign slow_link_good              = ctrl_r[2];
    assign inverted_polarity_override  = ctrl_r[3];
    assign auto_polarity_en            = ctrl_r[4];
    assign sqe_test_en                 = ctrl_r[5];
    assign long_tx_guard_en            = ctrl_r[6];
    assign phy_status_pol_bit          = ctrl_r[7];
    assign reg_ack                     = ack_r;
    assign reg_rdata                   = rdata_r;
    assign page_select                 = pg_r;
    assign pmd_control_status          = pmd_r;
    assign dsp_configuration           = dsp_r;
    assign signal_detect_configuration = sd_r;
    assign test_data_port              = tst_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // bus answer: one ack per request, one cycle later, mapped or not
    a_ack_answer: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr || reg_rd) |=> reg_ack)
        else $error("request not acknowledged");
    a_ack_idle: assert property (@(posedge clk) disable iff (!rstn)
        !(reg_wr || reg_rd) |=> !reg_ack)
        else $error("ack without request");
    // control word: stored bits, status bit never stored, read view
    a_write_bits: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `OFF_TBT_CONTROL) |=>
        ctl_r[`BIT_LOOP:`BIT_POL_OVERRIDE] == $past(reg_wdata[`BIT_LOOP:`BIT_POL_OVERRIDE]) &&
        !ctl_r[`BIT_POL_STATUS])
        else $error("control write not stored as masked");
    a_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
        (reg_rd && !reg_wr && reg_addr == `OFF_TBT_CONTROL) |=>
        reg_rdata[15:9] == 7'h00 && reg_rdata[2])
        else $error("unused bits not read as zero");
    a_read_pol: assert property (@(posedge clk) disable iff (!rstn)
        (reg_rd && !reg_wr && reg_addr == `OFF_TBT_CONTROL) |=>
        reg_rdata[`BIT_POL_STATUS] == $past(pl_bus.latched))
        else $error("polarity status not in read view");
    // phy controls; rstn in the antecedent skips the edge of release,
    // where the outputs still show their reset value
    a_loop_or: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> slow_loopback_en == $past(ctl_r[`BIT_LOOP] | ctrl_loopback))
        else $error("loopback not the or of sources");
    a_loop_on: assert property (@(posedge clk) disable iff (!rstn)
        (rstn && ctrl_loopback) |=> slow_loopback_en)
        else $error("control loopback not passed on");
    a_pulse_off: assert property (@(posedge clk) disable iff (!rstn)
        mac_slow_link_override |=> !normal_link_pulse_en)
        else $error("link pulses not suppressed");
    a_pulse_bit: assert property (@(posedge clk) disable iff (!rstn)
        ctl_r[`BIT_LP_SUPPRESS] |=> !normal_link_pulse_en)
        else $error("link pulses not suppressed by bit");
    a_pulse_on: assert property (@(posedge clk) disable iff (!rstn)
        (rstn && !ctl_r[`BIT_LP_SUPPRESS] && !mac_slow_link_override) |=> normal_link_pulse_en)
        else $error("link pulses stopped without cause");
    a_link_forced: assert property (@(posedge clk) disable iff (!rstn)
        ctl_r[`BIT_FORCE_LINK] |=> slow_link_good)
        else $error("forced link not reported");
    a_link_mac: assert property (@(posedge clk) disable iff (!rstn)
        (rstn && mac_slow_link_override) |=> slow_link_good)
        else $error("mac forced link not reported");
    a_link_normal: assert property (@(posedge clk) disable iff (!rstn)
        (rstn && !ctl_r[`BIT_FORCE_LINK] && !mac_slow_link_override) |=>
        slow_link_good == $past(link_detected))
        else $error("link status not from detection");
    a_pol_force: assert property (@(posedge clk) disable iff (!rstn)
        ##1 inverted_polarity_override == $past(ctl_r[`BIT_POL_OVERRIDE]))
        else $error("polarity override mismatch");
    a_autopol: assert property (@(posedge clk) disable iff (!rstn)
        ctl_r[`BIT_AUTOPOL_OFF] |=> !auto_polarity_en)
        else $error("auto polarity not disabled");
    a_autopol_on: assert property (@(posedge clk) disable iff (!rstn)
        (rstn && !ctl_r[`BIT_AUTOPOL_OFF]) |=> auto_polarity_en)
        else $error("auto polarity not enabled");
    a_sqe_gate: assert property (@(posedge clk) disable iff (!rstn)
        (speed_fast || full_duplex) |=> !sqe_test_en)
        else $error("sqe test on outside half duplex ten");
    a_sqe_on: assert property (@(posedge clk) disable iff (!rstn)
        (rstn && !speed_fast && !full_duplex) |=> sqe_test_en == !$past(ctl_r[`BIT_SQE_OFF]))
        else $error("sqe test not set by bit in half duplex ten");
    a_guard_off: assert property (@(posedge clk) disable iff (!rstn)
        ctl_r[`BIT_GUARD_OFF] |=> !long_tx_guard_en)
        else $error("jabber guard not disabled");
    a_guard_on: assert property (@(posedge clk) disable iff (!rstn)
        (rstn && !ctl_r[`BIT_GUARD_OFF]) |=> long_tx_guard_en)
        else $error("jabber guard not enabled");
    // polarity flag and its status copy
    a_pol_clear: assert property (@(posedge clk) disable iff (!rstn)
        (pol_clear && !pl_bus.detect) |=> !pl_bus.latched)
        else $error("polarity flag not cleared on read");
    a_pol_set: assert property (@(posedge clk) disable iff (!rstn)
        pl_bus.detect |=> pl_bus.latched ##1 phy_status_pol_bit)
        else $error("polarity event lost");
    a_pol_copy: assert property (@(posedge clk) disable iff (!rstn)
        ##1 phy_status_pol_bit == $past(pl_bus.latched))
        else $error("status copy differs from flag");
    // tuning stores keep exactly what software wrote
    a_page_store: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `OFF_PAGE_SELECT) |=> page_select == $past(reg_wdata))
        else $error("page select write lost");
    a_pmd_store: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `OFF_PMD_CONTROL) |=> pmd_control_status == $past(reg_wdata))
        else $error("pmd control write lost");
    a_dsp_store: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `OFF_DSP_CONFIG) |=> dsp_configuration == $past(reg_wdata))
        else $error("dsp configuration write lost");
    a_detect_store: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `OFF_SIG_DETECT) |=>
        signal_detect_configuration == $past(reg_wdata))
        else $error("signal detect write lost");
    a_test_store: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `OFF_TEST_DATA) |=> test_data_port == $past(reg_wdata))
        else $error("test data write lost");
endmodule // tenbase_t_phy_control

// File: verification/phy_side_model.sv
`timescale 1ns/100ps
module phy_side_model (
    // knobs from the bench
    input  wire logic [4:0] knobs,
    input  wire logic       pol_evt,
    input  wire logic       sts_evt,
    // phy side levels
    output logic            ctrl_loopback,
    output logic            mac_slow_link_override,
    output logic            link_detected,
    output logic            speed_fast,
    output logic            full_duplex,
    output logic            polarity_inverted_seen,
    output logic            phy_status_word_read
);
    // plain levels: the mac and phy drive these steadily, no release state
    assign {full_duplex, speed_fast, link_detected} = knobs[4:2];
    assign {mac_slow_link_override, ctrl_loopback} = knobs[1:0];
    assign polarity_inverted_seen = pol_evt;
    assign phy_status_word_read   = sts_evt;
endmodule // phy_side_model

// File: verification/tenbase_t_phy_control_tb.sv
`timescale 1ns/100ps
`include "tbt_consts.svh"
module tenbase_t_phy_control_tb;
    import tbt_pkg::*;
    logic      clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_ack;
    reg_addr_t reg_addr = 8'h00;
    reg_word_t reg_wdata = 16'h0000, reg_rdata, w;
    reg_word_t page_select, pmd_control_status, dsp_configuration;
    reg_word_t signal_detect_configuration, test_data_port;
    logic      ctrl_loopback, mac_slow_link_override, link_detected, speed_fast, full_duplex;
    logic      polarity_inverted_seen, phy_status_word_read, phy_status_pol_bit;
    logic      slow_loopback_en, normal_link_pulse_en, slow_link_good, auto_polarity_en;
    logic      inverted_polarity_override, sqe_test_en, long_tx_guard_en;
    logic [4:0]  knobs = 5'h00;
    logic        pol_evt = 1'b0, sts_evt = 1'b0;
    logic [16:0] q[$];
    logic [16:0] note;
    int          n_fail = 0, tests_run = 0;
    reg_addr_t   offs[5] = '{8'hCC, 8'hE4, 8'hFC, 8'hF4, 8'hF8};
    reg_word_t   vals[5] = '{16'h0001, 16'h189C, 16'h0000, 16'h5040, 16'h008C};

    tenbase_t_phy_control i_tenbase_t_phy_control (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_ack, .reg_rdata, .ctrl_loopback, .mac_slow_link_override,
        .link_detected, .polarity_inverted_seen, .phy_status_word_read, .speed_fast,
        .full_duplex, .slow_loopback_en, .normal_link_pulse_en, .slow_link_good,
        .inverted_polarity_override, .auto_polarity_en, .sqe_test_en, .long_tx_guard_en,
        .phy_status_pol_bit, .page_select, .pmd_control_status, .dsp_configuration,
        .signal_detect_configuration, .test_data_port);
    phy_side_model i_phy_side_model (.knobs, .pol_evt, .sts_evt, .ctrl_loopback,
        .mac_slow_link_override, .link_detected, .speed_fast, .full_duplex,
        .polarity_inverted_seen, .phy_status_word_read);

    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input reg_word_t exp, input reg_word_t got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one request pulse; the expected answer is noted before the ack can come
    task automatic acc(input logic wr, input reg_addr_t a, input reg_word_t d,
                       input reg_word_t x);
        @(posedge clk);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= d;
        q.push_back({!wr, x});
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    function automatic logic [6:0] exp_ctl(input reg_word_t v, input logic [4:0] k);
        return {v[8] | k[0], !(v[7] | k[1]), v[6] | k[1] | k[2], v[5], !v[3],
                !v[1] & !k[3] & !k[4], !v[0]};
    endfunction
    // outputs trail a write by two edges, so three edges is settled
    task automatic ctl_chk(input reg_word_t v);
        logic [6:0] e;
        repeat (3) @(posedge clk);
        #1;
        e = exp_ctl(v, knobs);
        chk("loopback", 16'(e[6]), 16'(slow_loopback_en));
        chk("link_pulse", 16'(e[5]), 16'(normal_link_pulse_en));
        chk("link_good", 16'(e[4]), 16'(slow_link_good));
        chk("pol_override", 16'(e[3]), 16'(inverted_polarity_override));
        chk("autopol", 16'(e[2]), 16'(auto_polarity_en));
        chk("sqe", 16'(e[1]), 16'(sqe_test_en));
        chk("guard", 16'(e[0]), 16'(long_tx_guard_en));
    endtask
    task automatic pol_pulse;
        @(posedge clk);
        pol_evt <= 1'b1;
        @(posedge clk);
        pol_evt <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("pol_flag", 16'h0001, {15'h0000, phy_status_pol_bit});
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (reg_ack === 1'b1) begin
            if (q.size() == 0) begin
                chk("stray_ack", 16'h0000, 16'h0001);
            end else begin
                note = q.pop_front();
                if (note[16]) chk("rdata", note[15:0], reg_rdata);
            end
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(83));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        acc(1'b0, `OFF_TBT_CONTROL, 16'h0000, `TBT_RESET);
        ctl_chk(`TBT_RESET);
        $display("test reset done");
        for (int i = 0; i < 5; i++) acc(1'b1, offs[i], vals[i], 16'h0000);
        for (int i = 0; i < 5; i++) acc(1'b0, offs[i], 16'h0000, vals[i]);
        chk("page_select", 16'h0001, page_select);
        chk("pmd_control", 16'h189C, pmd_control_status);
        chk("test_data", 16'h0000, test_data_port);
        chk("dsp_config", 16'h5040, dsp_configuration);
        chk("sig_detect", 16'h008C, signal_detect_configuration);
        acc(1'b1, 8'h10, 16'hFFFF, 16'h0000);
        acc(1'b0, 8'h10, 16'h0000, 16'h0000);
        $display("test tuning done");
        acc(1'b1, `OFF_TBT_CONTROL, 16'hFFFF, 16'h0000);
        acc(1'b0, `OFF_TBT_CONTROL, 16'h0000, 16'h01EF);
        ctl_chk(16'h01EF);
        for (int i = 0; i < 14; i++) begin
            w = 16'($urandom) | `TBT_RSVD_ONE;
            @(posedge clk);
            knobs <= 5'($urandom);
            acc(1'b1, `OFF_TBT_CONTROL, w, 16'h0000);
            acc(1'b0, `OFF_TBT_CONTROL, 16'h0000, w & `TBT_WR_MASK | `TBT_RSVD_ONE);
            ctl_chk(w);
        end
        $display("test controls done");
        pol_pulse();
        acc(1'b0, `OFF_TBT_CONTROL, 16'h0000, w & `TBT_WR_MASK | 16'h0014);
        acc(1'b0, `OFF_TBT_CONTROL, 16'h0000, w & `TBT_WR_MASK | `TBT_RSVD_ONE);
        #1;
        chk("pol_clear", 16'h0000, {15'h0000, phy_status_pol_bit});
        pol_pulse();
        @(posedge clk);
        sts_evt <= 1'b1;
        @(posedge clk);
        sts_evt <= 1'b0;
        acc(1'b0, `OFF_TBT_CONTROL, 16'h0000, w & `TBT_WR_MASK | `TBT_RSVD_ONE);
        $display("test polarity done");
        repeat (4) @(posedge clk);
        chk("queue", 16'h0000, 16'(q.size()));
        wrap_up();
    end
endmodule // tenbase_t_phy_control_tb
